// ===== sbut_cfg.svh
`ifndef SBUT_CFG_SVH
`define SBUT_CFG_SVH

// Register addresses on the plain register port
`define SBUT_ADDR_MODE      8'h06
`define SBUT_ADDR_IRQ_REQ   8'h05
`define SBUT_ADDR_IRQ_EN    8'h04
`define SBUT_ADDR_EDGE_SEL  8'h0C

// Reset values
`define SBUT_MODE_RST       8'h00
`define SBUT_BYTE_RST       8'h00
`define SBUT_CNT_RST        16'h0000
`define SBUT_PSC_RST        6'h00
`define SBUT_SYNC_RST       4'h0

// Field positions
`define SBUT_SRC_HI         7
`define SBUT_SRC_LO         5
`define SBUT_DIV_HI         4
`define SBUT_DIV_LO         3
`define SBUT_BIT_HI         2
`define SBUT_BIT_LO         0
`define SBUT_EDGE_BIT       4
`define SBUT_TIMER_FLAG     2
`define SBUT_SEL_BASE       8

// Source codes of the mode register
`define SBUT_SRC_STOP       3'h0
`define SBUT_SRC_SYS        3'h1
`define SBUT_SRC_PA4        3'h3
`define SBUT_SRC_FAST       3'h4
`define SBUT_SRC_SLOW       3'h6
`define SBUT_SRC_PA0        3'h7

// Prescaler codes and terminal counts
`define SBUT_DIV1           2'h0
`define SBUT_DIV4           2'h1
`define SBUT_DIV16          2'h2
`define SBUT_DIV64          2'h3
`define SBUT_PSC_END4       6'h03
`define SBUT_PSC_END16      6'h0F
`define SBUT_PSC_END64      6'h3F
`define SBUT_PSC_ONE        6'h01
`define SBUT_CNT_ONE        16'h0001

// Index of each external source in the synchroniser vectors
`define SBUT_IX_PA4         0
`define SBUT_IX_PA0         1
`define SBUT_IX_FAST        2
`define SBUT_IX_SLOW        3
`define SBUT_N_SRC          4

`endif

// ===== sbut_pkg.sv
`include "sbut_cfg.svh"

package sbut_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sbut_bus_req_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  edge_sel;
    logic [7:0]  irq_req;
    logic [7:0]  irq_en;
    logic [15:0] count;
    logic [5:0]  psc;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic [3:0]  level;
    logic        prev_bit;
    logic [7:0]  rdata;
    logic [15:0] count_copy;
    logic        count_copy_vld;
    logic        irq_out;
  } sbut_state_t;

endpackage : sbut_pkg

// ===== sbut_timer.sv
`timescale 1ns/1ps
`include "sbut_cfg.svh"

// Behaviour
// - Mode bits 7..5 pick counter source: stop, system, -, PA4 fall, fast, -, slow, PA0 fall.
// - Prescaler divides the chosen source by 1, 4, 16 or 64 from mode bits 4..3.
// - Mode bits 2..0 pick counter bit 8 to 15 as interrupt source.
// - Sixteen-bit counter increments by one per prescaled clock unless a store loads it.
// - Store-counter instruction loads the counter from data memory.
// - Read-counter instruction copies the present count into data memory.
// - Interrupt fires on selected bit transition; edge-select bit 4 chooses direction.
// - Timer interrupt event sets bit 2 of the request flag register.
// - Bit n selected gives one request every 2^(n+1) prescaled clocks.
// - Stop source code halts the counter, which holds its value.
// - Flags set only by hardware; software clears them by writing the flag register.
// - Timer flag sets even while its interrupt enable bit is zero.

module sbut_timer (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire sbut_pkg::sbut_bus_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  input  wire logic                  store_counter_instruction,
  input  wire logic [15:0]           store_counter_value,
  input  wire logic                  read_counter_instruction,
  output logic [15:0]                read_counter_value,
  output logic                       read_counter_valid,
  input  wire logic                  port_a_bit0,
  input  wire logic                  port_a_bit4,
  input  wire logic                  fast_rc_oscillator,
  input  wire logic                  slow_rc_oscillator,
  output logic                       timer_irq
);

  sbut_pkg::sbut_state_t cur_ff;
  sbut_pkg::sbut_state_t nxt_st;

  logic [3:0]  raw_src;
  logic [3:0]  fall_evt;
  logic [3:0]  rise_evt;
  logic        src_tick;
  logic        pre_tick;
  logic [15:0] cnt_after;
  logic        sel_now;
  logic        bit_evt;
  logic [7:0]  rd_mux;

  // Prescaler terminal count for the chosen divider
  function automatic logic psc_done(input logic [5:0] psc, input logic [1:0] div);
    logic r;
    r = 1'b0;
    case (div)
      `SBUT_DIV1:  r = 1'b1;
      `SBUT_DIV4:  r = (psc[1:0] == `SBUT_PSC_END4);
      `SBUT_DIV16: r = (psc[3:0] == `SBUT_PSC_END16);
      `SBUT_DIV64: r = (psc == `SBUT_PSC_END64);
      default:     r = 1'b0;
    endcase
    return r;
  endfunction : psc_done

  // Counter bit 8 + sel feeds the interrupt edge detector
  function automatic logic sel_bit(input logic [15:0] cnt, input logic [2:0] sel);
    logic [7:0] hi;
    hi = cnt[15:`SBUT_SEL_BASE];
    return hi[sel];
  endfunction : sel_bit

  assign raw_src[`SBUT_IX_PA4]  = port_a_bit4;
  assign raw_src[`SBUT_IX_PA0]  = port_a_bit0;
  assign raw_src[`SBUT_IX_FAST] = fast_rc_oscillator;
  assign raw_src[`SBUT_IX_SLOW] = slow_rc_oscillator;

  always_comb begin
    nxt_st = cur_ff;

    // Three-stage synchroniser; a level is accepted only once stages two and three agree,
    // so a pin bouncing across a sample edge cannot be counted twice
    nxt_st.sync1 = raw_src;
    nxt_st.sync2 = cur_ff.sync1;
    nxt_st.sync3 = cur_ff.sync2;
    for (int i = 0; i < `SBUT_N_SRC; i++) begin
      if (cur_ff.sync2[i] == cur_ff.sync3[i]) begin
        nxt_st.level[i] = cur_ff.sync3[i];
      end
    end
    fall_evt = cur_ff.level & ~nxt_st.level;
    rise_evt = ~cur_ff.level & nxt_st.level;

    // Source selection; reserved codes behave as stop
    case (cur_ff.mode[`SBUT_SRC_HI:`SBUT_SRC_LO])
      `SBUT_SRC_STOP: src_tick = 1'b0;
      `SBUT_SRC_SYS:  src_tick = 1'b1;
      `SBUT_SRC_PA4:  src_tick = fall_evt[`SBUT_IX_PA4];
      `SBUT_SRC_FAST: src_tick = rise_evt[`SBUT_IX_FAST];
      `SBUT_SRC_SLOW: src_tick = rise_evt[`SBUT_IX_SLOW];
      `SBUT_SRC_PA0:  src_tick = fall_evt[`SBUT_IX_PA0];
      default:        src_tick = 1'b0;
    endcase

    // Prescaler
    pre_tick = src_tick && psc_done(cur_ff.psc, cur_ff.mode[`SBUT_DIV_HI:`SBUT_DIV_LO]);
    if (src_tick) begin
      if (pre_tick) begin
        nxt_st.psc = `SBUT_PSC_RST;
      end else begin
        nxt_st.psc = cur_ff.psc + `SBUT_PSC_ONE;
      end
    end

    // Counter: a load from data memory wins over a count in the same cycle
    cnt_after = cur_ff.count;
    if (store_counter_instruction) begin
      cnt_after = store_counter_value;
    end else if (pre_tick) begin
      cnt_after = cur_ff.count + `SBUT_CNT_ONE;
    end
    nxt_st.count = cnt_after;

    // Edge on the selected bit; one chosen direction gives one event per 2^(n+1) counts
    sel_now = sel_bit(cnt_after, cur_ff.mode[`SBUT_BIT_HI:`SBUT_BIT_LO]);
    nxt_st.prev_bit = sel_now;
    if (cur_ff.edge_sel[`SBUT_EDGE_BIT]) begin
      bit_evt = cur_ff.prev_bit && !sel_now;
    end else begin
      bit_evt = !cur_ff.prev_bit && sel_now;
    end

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        `SBUT_ADDR_MODE:     nxt_st.mode = bus_req.wdata;
        `SBUT_ADDR_EDGE_SEL: nxt_st.edge_sel = bus_req.wdata;
        `SBUT_ADDR_IRQ_EN:   nxt_st.irq_en = bus_req.wdata;
        `SBUT_ADDR_IRQ_REQ:  nxt_st.irq_req = cur_ff.irq_req & bus_req.wdata;
        default:             nxt_st.irq_req = cur_ff.irq_req;
      endcase
    end

    // Hardware set is applied last so it wins over a clear in the same cycle,
    // and it ignores the enable bit
    if (bit_evt) begin
      nxt_st.irq_req[`SBUT_TIMER_FLAG] = 1'b1;
    end
    nxt_st.irq_out = nxt_st.irq_req[`SBUT_TIMER_FLAG] & nxt_st.irq_en[`SBUT_TIMER_FLAG];

    // Read data stand only in the cycle after the strobe; unmapped reads return zero
    case (bus_req.addr)
      `SBUT_ADDR_MODE:     rd_mux = cur_ff.mode;
      `SBUT_ADDR_EDGE_SEL: rd_mux = cur_ff.edge_sel;
      `SBUT_ADDR_IRQ_EN:   rd_mux = cur_ff.irq_en;
      `SBUT_ADDR_IRQ_REQ:  rd_mux = cur_ff.irq_req;
      default:             rd_mux = `SBUT_BYTE_RST;
    endcase
    nxt_st.rdata = bus_req.rd ? rd_mux : `SBUT_BYTE_RST;

    // Copy of the count as it stood before this edge
    nxt_st.count_copy_vld = read_counter_instruction;
    if (read_counter_instruction) begin
      nxt_st.count_copy = cur_ff.count;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff.mode           <= `SBUT_MODE_RST;
      cur_ff.edge_sel       <= `SBUT_BYTE_RST;
      cur_ff.irq_req        <= `SBUT_BYTE_RST;
      cur_ff.irq_en         <= `SBUT_BYTE_RST;
      cur_ff.count          <= `SBUT_CNT_RST;
      cur_ff.psc            <= `SBUT_PSC_RST;
      cur_ff.sync1          <= `SBUT_SYNC_RST;
      cur_ff.sync2          <= `SBUT_SYNC_RST;
      cur_ff.sync3          <= `SBUT_SYNC_RST;
      cur_ff.level          <= `SBUT_SYNC_RST;
      cur_ff.prev_bit       <= 1'b0;
      cur_ff.rdata          <= `SBUT_BYTE_RST;
      cur_ff.count_copy     <= `SBUT_CNT_RST;
      cur_ff.count_copy_vld <= 1'b0;
      cur_ff.irq_out        <= 1'b0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign bus_rdata          = cur_ff.rdata;
  assign read_counter_value = cur_ff.count_copy;
  assign read_counter_valid = cur_ff.count_copy_vld;
  assign timer_irq          = cur_ff.irq_out;

endmodule : sbut_timer

// ===== sbut_timer_sva.sv
`timescale 1ns/1ps
module sbut_sva (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire sbut_pkg::sbut_bus_req_t bus_req,
  input wire logic [7:0]              bus_rdata,
  input wire logic                    store_counter_instruction,
  input wire logic [15:0]             store_counter_value,
  input wire logic                    read_counter_instruction,
  input wire logic [15:0]             read_counter_value,
  input wire logic                    read_counter_valid,
  input wire logic                    timer_irq
);
  logic [7:0] mode_q;
  logic       en_q;
  logic       rq;
  assign rq = read_counter_instruction && !store_counter_instruction;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= 8'h00;
      en_q   <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == 8'h06) begin
      mode_q <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == 8'h04) begin
      en_q <= bus_req.wdata[2];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not idle");
  mode_back_a: assert property (bus_req.wr && bus_req.addr == 8'h06 ##2 bus_req.rd && bus_req.addr == 8'h06
    |=> bus_rdata == $past(bus_req.wdata, 3)) else $error("mode readback wrong");
  unmapped_zero_a: assert property (bus_req.rd && !(bus_req.addr inside {8'h04, 8'h05, 8'h06, 8'h0C})
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  store_load_a: assert property (store_counter_instruction ##1 read_counter_instruction
    |=> read_counter_value == $past(store_counter_value, 2)) else $error("store not loaded");
  copy_pulse_a: assert property (read_counter_valid == $past(read_counter_instruction))
    else $error("copy pulse wrong");
  count_step_a: assert property (mode_q[7:3] == 5'h04 ##1 rq && mode_q[7:3] == 5'h04 ##1 rq
    && mode_q[7:3] == 5'h04 |=> read_counter_value == $past(read_counter_value) + 16'h0001) else $error("no step");
  stop_hold_a: assert property (mode_q[7:5] == 3'h0 ##1 rq && mode_q[7:5] == 3'h0 ##1 rq
    && mode_q[7:5] == 3'h0 |=> $stable(read_counter_value)) else $error("stopped count moved");
  irq_gate_a: assert property (timer_irq |-> en_q) else $error("request without enable");
  flag_read_a: assert property (bus_req.rd && bus_req.addr == 8'h05 && timer_irq |=> bus_rdata[2])
    else $error("flag not read back");
endmodule : sbut_sva

// ===== sbut_timer_test.sv
`timescale 1ns/1ps
module sbut_timer_test;
  logic                    clk, sys_rst, sci, rci, rd_d, irq, rcvld;
  logic [3:0]              p;
  logic [7:0]              rdata, m;
  logic [15:0]             scv, rcv, last, v;
  logic [17:0]             e;
  logic [7:0]              qb[$];
  logic [17:0]             qc[$];
  logic [2:0]              srcs[4] = '{3'h3, 3'h4, 3'h6, 3'h7};
  int                      n_errors, comparisons, cyc, n;
  sbut_pkg::sbut_bus_req_t req;
  sbut_timer dut (.clk(clk), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(rdata),
    .store_counter_instruction(sci), .store_counter_value(scv), .read_counter_instruction(rci),
    .read_counter_value(rcv), .read_counter_valid(rcvld), .port_a_bit0(p[3]), .port_a_bit4(p[0]),
    .fast_rc_oscillator(p[1]), .slow_rc_oscillator(p[2]), .timer_irq(irq));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) qb.push_back(d);
    req <= '{a, w ? d : 8'h00, w, !w};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : bus
  // No idle cycle after a store so a counter read can follow at once
  task automatic st(input logic [15:0] x);
    sci <= 1'b1;
    scv <= x;
    @(posedge clk);
    sci <= 1'b0;
  endtask : st
  // Two captures g edges apart; first entry f, second is an expected difference
  task automatic pair(input int g, input logic [17:0] f, input logic [15:0] d);
    qc.push_back(f);
    qc.push_back({2'b01, d});
    rci <= 1'b1;
    @(posedge clk);
    if (g > 1) begin
      rci <= 1'b0;
      repeat (g - 1) @(posedge clk);
      rci <= 1'b1;
    end
    @(posedge clk);
    rci <= 1'b0;
    @(posedge clk);
  endtask : pair
  task automatic pulse(input int i);
    p[i] <= ~p[i];
    repeat (6) @(posedge clk);
    p[i] <= ~p[i];
    repeat (6) @(posedge clk);
  endtask : pulse
  always @(posedge clk) begin
    rd_d <= req.rd;
    if (rd_d) chk("rdata", {8'h00, rdata}, {8'h00, qb.pop_front()});
    if (rcvld) begin
      e = qc.pop_front();
      if (!e[17]) chk("count", e[16] ? rcv - last : rcv, e[15:0]);
      last = rcv;
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {sys_rst, sci, rci} = 3'h4;
    scv = 16'h0000;
    req = '0;
    p = 4'h9;
    void'($urandom(32'h9EA3));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (srcs[i]) bus(1'b0, 8'h03 + {srcs[i], 1'b0}, 8'h00);
    m = 8'($urandom);
    bus(1'b1, 8'h06, m);
    bus(1'b0, 8'h06, m);
    bus(1'b1, 8'h06, 8'h00);
    v = 16'($urandom);
    st(v);
    pair(1, {2'b00, v}, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 8'h06, {3'(s), 5'h00});
      repeat (8) @(posedge clk);
      pair(64, 18'h20000, s == 1 ? 16'h0040 : 16'h0000);
    end
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, 8'h06, {3'h1, 2'(d), 3'h0});
      repeat (8) @(posedge clk);
      if (d == 0) pair(1, 18'h20000, 16'h0001);
      pair(64, 18'h20000, 16'h0040 >> (2 * d));
    end
    bus(1'b1, 8'h06, 8'h20);
    st(16'hFFFC);
    pair(8, 18'h0FFFC, 16'h0008);
    foreach (srcs[i]) begin
      bus(1'b1, 8'h06, {srcs[i], 5'h00});
      n = $urandom % 8 + 1;
      repeat (8) @(posedge clk);
      fork
        pair(12 * n + 16, 18'h20000, 16'(n));
        repeat (n) pulse(i);
      join
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h04, {5'h00, 1'(k), 2'h0});
      bus(1'b1, 8'h0C, {3'h0, 1'(k), 4'h0});
      for (int b = 0; b < 8; b++) begin
        bus(1'b1, 8'h06, {5'h04, 3'(b)});
        // Start 16 counts before the chosen bit turns in the chosen direction
        st((16'h0100 << (b + k)) - 16'h0010);
        bus(1'b1, 8'h05, 8'hFB);
        bus(1'b0, 8'h05, 8'h00);
        repeat (20) @(posedge clk);
        bus(1'b0, 8'h05, 8'h04);
        chk("irq", {15'h0000, irq}, {15'h0000, 1'(k)});
      end
    end
    close_out();
  end
endmodule : sbut_timer_test
bind sbut_timer sbut_sva sva_i (.*);
